/* pkg/isms_pkg.sv */
// Shared constants for the two-wire serial memory link: device and master.
// Assumes both ends run on one pclk and meet through isms_link_if.
// Operation
// - Master sends type, select, direction word
// - Ignore transfer on type code mismatch
// - Select bits must equal strap pins
// - Eighth bit low writes, high reads
// - Matching address word acknowledged on ninth clock
// - Two address bytes, high first, each acknowledged
// - Write bytes acknowledged before next is sent
// - Read sends eight bits, then releases line
// - No busy not-acknowledge, no write wait
// - Write-protect high blocks all array writes
// - Master zeroes upper three high-address bits; the device ignores them and the bench sends them set
// - Byte write ends with stop condition
// - Write address increments and wraps to zero
// - Commit each byte when its acknowledge ends
// - Current-address read returns last plus one
// - Address counter undefined until first access; the device resets it to zero
// - Random read uses repeated start then read
// - Master not-acknowledges last byte, then stops
// - Acknowledged reads continue at incrementing addresses
// - Sample on clock rise, drive after fall
// - Start and stop detected while clock high
// - Reads served whatever write-protect level
`default_nettype none
package isms_pkg;
    localparam int          MEM_DEPTH     = 8192;
    localparam int          ADDR_W        = 13;
    localparam int          TYPE_W        = 4;
    localparam int          SEL_W         = 3;
    // Arbitrary value, not tied to any product
    localparam logic [3:0]  DEF_TYPE_CODE = 4'h6;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [1:0]  SLOT_DEV      = 2'h0;
    localparam logic [1:0]  SLOT_AHI      = 2'h1;
    localparam logic [1:0]  SLOT_ALO      = 2'h2;
    localparam logic [1:0]  SLOT_DATA     = 2'h3;
    // Master register map
    localparam logic [7:0]  REG_TX        = 8'h00;
    localparam logic [7:0]  REG_CMD       = 8'h04;
    localparam logic [7:0]  REG_STAT      = 8'h08;
    localparam logic [7:0]  REG_RX        = 8'h0C;
    localparam int          CMD_START     = 0;
    localparam int          CMD_STOP      = 1;
    localparam int          CMD_READ      = 2;
    localparam int          CMD_NACK      = 3;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_ACK      = 1;
    // Serial clock quarter period in pclk cycles
    localparam int          QTR_CYCLES    = 12;
    typedef enum logic [2:0] {
        D_IDLE, D_RX, D_RXACK, D_TX, D_TXACK
    } isms_dstate_t;
    typedef enum logic [1:0] {
        M_IDLE, M_START, M_BITS, M_STOP
    } isms_mstate_t;
endpackage : isms_pkg
`default_nettype wire

/* pkg/isms_link_if.sv */
// Two-wire link between master and device ends.
// Assumes open-drain data; enable low means the end pulls low.
`default_nettype none
interface isms_link_if;
    logic scl;
    logic sda;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    // Wired-AND of both drivers with pull-up
    assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
    modport master (
        output scl,
        output m_sda_o,
        output m_sda_oe_n,
        input  sda
    );
    modport device (
        input  scl,
        input  sda,
        output d_sda_o,
        output d_sda_oe_n
    );
endinterface : isms_link_if
`default_nettype wire

/* design/isms_device.sv */
// Serial memory slave: byte array behind the two-wire link.
// Assumes pclk far faster than scl; all pins are synchronised.
`default_nettype none
module isms_device
    import isms_pkg::*;
#(
    parameter logic [TYPE_W-1:0] TYPE_CODE = DEF_TYPE_CODE,
    parameter int                DEPTH     = MEM_DEPTH
)(
    // Clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    // Straps and protection
    input  wire logic     select_strap_high,
    input  wire logic     select_strap_mid,
    input  wire logic     select_strap_low,
    input  wire logic     write_protect,
    // Link
    isms_link_if.device   link
);

    logic [5:0]         pin_s1_q;
    logic [5:0]         pin_s2_q;
    logic               scl_p_q;
    logic               sda_p_q;
    logic               scl_s;
    logic               sda_s;
    logic               wp_s;
    logic [SEL_W-1:0]   strap_s;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;
    isms_dstate_t       state_q;
    logic [3:0]         cnt_q;
    logic [1:0]         slot_q;
    logic [7:0]         rx_q;
    logic [7:0]         tx_q;
    logic [4:0]         ahi_q;
    logic [ADDR_W-1:0]  addr_q;
    logic               dir_rd_q;
    logic               sda_oe_n_q;
    logic [7:0]         mem [DEPTH];
    logic [7:0]         mem_rd;
    logic               commit;
    logic               dev_match;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 6'h3F;
            pin_s2_q <= 6'h3F;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end else begin
            pin_s1_q <= {link.scl, link.sda, write_protect,
                         select_strap_high, select_strap_mid,
                         select_strap_low};
            pin_s2_q <= pin_s1_q;
            scl_p_q  <= pin_s2_q[5];
            sda_p_q  <= pin_s2_q[4];
        end
    end

    assign scl_s    = pin_s2_q[5];
    assign sda_s    = pin_s2_q[4];
    assign wp_s     = pin_s2_q[3];
    assign strap_s  = pin_s2_q[2:0];
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    assign mem_rd = mem[addr_q];
    assign dev_match = (rx_q[7:4] == TYPE_CODE)
                     && (rx_q[3:1] == strap_s);

    // Commit as the acknowledge clock ends, unless protected
    assign commit = (state_q == D_RXACK) && scl_fall
                  && (slot_q == SLOT_DATA) && !wp_s;

    // Byte array
    always_ff @(posedge pclk) begin
        if (commit) begin
            mem[addr_q] <= rx_q;
        end
    end

    // Link sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= D_IDLE;
            cnt_q      <= 4'h0;
            slot_q     <= SLOT_DEV;
            rx_q       <= 8'h00;
            tx_q       <= 8'h00;
            ahi_q      <= 5'h00;
            addr_q     <= '0;
            dir_rd_q   <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else if (stop_det) begin
            state_q    <= D_IDLE;
            sda_oe_n_q <= 1'b1;
        end else if (start_det) begin
            state_q    <= D_RX;
            cnt_q      <= 4'h0;
            slot_q     <= SLOT_DEV;
            sda_oe_n_q <= 1'b1;
        end else begin
            case (state_q)
                D_IDLE: begin
                    sda_oe_n_q <= 1'b1;
                end
                D_RX: begin
                    if (scl_rise) begin
                        rx_q  <= {rx_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        if (slot_q == SLOT_DEV && !dev_match) begin
                            state_q <= D_IDLE;
                        end else begin
                            state_q    <= D_RXACK;
                            sda_oe_n_q <= 1'b0;
                            if (slot_q == SLOT_DEV) begin
                                dir_rd_q <= rx_q[0];
                            end
                            if (slot_q == SLOT_AHI) begin
                                ahi_q <= rx_q[4:0];
                            end
                            if (slot_q == SLOT_ALO) begin
                                addr_q <= {ahi_q, rx_q};
                            end
                        end
                    end
                end
                D_RXACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (slot_q == SLOT_DEV && dir_rd_q) begin
                            state_q    <= D_TX;
                            tx_q       <= mem_rd;
                            sda_oe_n_q <= mem_rd[7];
                            addr_q     <= addr_q + 1'b1;
                        end else begin
                            state_q    <= D_RX;
                            sda_oe_n_q <= 1'b1;
                            if (slot_q == SLOT_DATA) begin
                                addr_q <= addr_q + 1'b1;
                            end else begin
                                slot_q <= slot_q + 2'h1;
                            end
                        end
                    end
                end
                D_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            state_q    <= D_TXACK;
                            sda_oe_n_q <= 1'b1;
                        end else begin
                            tx_q       <= {tx_q[6:0], 1'b0};
                            sda_oe_n_q <= tx_q[6];
                        end
                    end
                end
                D_TXACK: begin
                    if (scl_rise) begin
                        rx_q[0] <= sda_s;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (!rx_q[0]) begin
                            state_q    <= D_TX;
                            tx_q       <= mem_rd;
                            sda_oe_n_q <= mem_rd[7];
                            addr_q     <= addr_q + 1'b1;
                        end else begin
                            state_q    <= D_IDLE;
                            sda_oe_n_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q    <= D_IDLE;
                    sda_oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Open-drain data: only ever pulls low
    assign link.d_sda_o    = 1'b0;
    assign link.d_sda_oe_n = sda_oe_n_q;

endmodule : isms_device
`default_nettype wire

/* design/isms_master.sv */
// Two-wire bus master driven by APB registers, one byte per command.
// Assumes a single device and no clock stretching.
`default_nettype none
module isms_master
    import isms_pkg::*;
#(
    parameter int QTR = QTR_CYCLES
)(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic [31:0]  prdata,
    output var  logic         pready,
    output var  logic         pslverr,
    // Link
    isms_link_if.master       link
);

    isms_mstate_t  state_q;
    logic [15:0]   qcnt_q;
    logic          tick;
    logic [1:0]    ph_q;
    logic [3:0]    bit_q;
    logic [7:0]    tx_q;
    logic [7:0]    sh_q;
    logic [7:0]    rx_q;
    logic          stop_q;
    logic          read_q;
    logic          nack_q;
    logic          ack_q;
    logic          scl_q;
    logic          sda_oe_n_q;
    logic [1:0]    sda_sy_q;
    logic          wr_acc;
    logic          launch;
    logic [31:0]   rd_mux;
    logic          mapped;

    assign pready = penable;
    assign wr_acc = psel & penable & pwrite;
    assign launch = wr_acc && paddr == REG_CMD && state_q == M_IDLE;
    assign tick   = qcnt_q == 16'(QTR - 1);
    assign mapped = paddr == REG_TX || paddr == REG_CMD
                 || paddr == REG_STAT || paddr == REG_RX;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            REG_TX:   rd_mux[7:0] = tx_q;
            REG_STAT: begin
                rd_mux[STAT_BUSY] = state_q != M_IDLE;
                rd_mux[STAT_ACK]  = ack_q;
            end
            REG_RX:   rd_mux[7:0] = rx_q;
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer, latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            tx_q    <= 8'h00;
        end else begin
            if (psel && !penable) begin
                prdata  <= rd_mux;
                pslverr <= !mapped;
            end
            if (wr_acc && paddr == REG_TX) begin
                tx_q <= pwdata[7:0];
            end
        end
    end

    // Data line synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_sy_q <= 2'h3;
        end else begin
            sda_sy_q <= {sda_sy_q[0], link.sda};
        end
    end

    // Serial clock divider and bit sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= M_IDLE;
            qcnt_q     <= 16'h0000;
            ph_q       <= 2'h0;
            bit_q      <= 4'h0;
            sh_q       <= 8'h00;
            rx_q       <= 8'h00;
            stop_q     <= 1'b0;
            read_q     <= 1'b0;
            nack_q     <= 1'b0;
            ack_q      <= 1'b0;
            scl_q      <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else if (launch) begin
            state_q <= pwdata[CMD_START] ? M_START : M_BITS;
            qcnt_q  <= 16'h0000;
            ph_q    <= 2'h0;
            bit_q   <= 4'h0;
            sh_q    <= tx_q;
            stop_q  <= pwdata[CMD_STOP];
            read_q  <= pwdata[CMD_READ];
            nack_q  <= pwdata[CMD_NACK];
        end else if (state_q != M_IDLE) begin
            qcnt_q <= tick ? 16'h0000 : qcnt_q + 16'h0001;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
                case (state_q)
                    M_START: begin
                        case (ph_q)
                            2'h0: begin
                                scl_q      <= 1'b0;
                                sda_oe_n_q <= 1'b1;
                            end
                            2'h1: scl_q      <= 1'b1;
                            2'h2: sda_oe_n_q <= 1'b0;
                            default: begin
                                scl_q   <= 1'b0;
                                state_q <= M_BITS;
                            end
                        endcase
                    end
                    M_BITS: begin
                        case (ph_q)
                            2'h0: begin
                                if (bit_q == BITS_PER_BYTE) begin
                                    sda_oe_n_q <= read_q ? nack_q : 1'b1;
                                end else begin
                                    sda_oe_n_q <= read_q | sh_q[7];
                                end
                            end
                            2'h1: scl_q <= 1'b1;
                            2'h2: begin
                                if (bit_q == BITS_PER_BYTE) begin
                                    ack_q <= ~sda_sy_q[1];
                                end else begin
                                    sh_q <= {sh_q[6:0], sda_sy_q[1]};
                                end
                            end
                            default: begin
                                scl_q <= 1'b0;
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == BITS_PER_BYTE) begin
                                    rx_q    <= sh_q;
                                    state_q <= stop_q ? M_STOP : M_IDLE;
                                end
                            end
                        endcase
                    end
                    M_STOP: begin
                        case (ph_q)
                            2'h0: sda_oe_n_q <= 1'b0;
                            2'h1: scl_q      <= 1'b1;
                            2'h2: sda_oe_n_q <= 1'b1;
                            default: state_q <= M_IDLE;
                        endcase
                    end
                    default: state_q <= M_IDLE;
                endcase
            end
        end
    end

    assign link.scl        = scl_q;
    assign link.m_sda_o    = 1'b0;
    assign link.m_sda_oe_n = sda_oe_n_q;

endmodule : isms_master
`default_nettype wire

/* verification/isms_link_assertions.sv */
// Assertion checker watching the two-wire link between master and device.
// Assumes it sits beside the link interface, sampled on pclk.
`default_nettype none
module isms_link_checker
    import isms_pkg::*;
#(
    parameter int                QTR       = QTR_CYCLES,
    parameter logic [TYPE_W-1:0] TYPE_CODE = DEF_TYPE_CODE
)(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Link
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic m_sda_o,
    input  wire logic m_sda_oe_n,
    input  wire logic d_sda_o,
    input  wire logic d_sda_oe_n,
    // Straps
    input  wire logic select_strap_high,
    input  wire logic select_strap_mid,
    input  wire logic select_strap_low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD_MAX = 40 * QTR;
    logic        scl_q, sda_q, first_q, dir_q, match_q;
    logic [3:0]  bit_q;
    logic [7:0]  word_q;
    logic [15:0] low_q;
    logic [2:0]  strap;
    logic        rise, start;
    assign strap = {select_strap_high, select_strap_mid, select_strap_low};
    assign rise  = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;

    // Line history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Bit position and first byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_q   <= 4'h0;
            first_q <= 1'b1;
            word_q  <= 8'h00;
        end else if (start) begin
            bit_q   <= 4'h0;
            first_q <= 1'b1;
            word_q  <= 8'h00;
        end else if (rise) begin
            bit_q   <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            first_q <= (bit_q == 4'h8) ? 1'b0 : first_q;
            word_q  <= (bit_q == 4'h8) ? word_q : {word_q[6:0], sda};
        end
    end
    // Direction and address match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q   <= 1'b0;
            match_q <= 1'b0;
        end else if (start) begin
            match_q <= 1'b0;
        end else if (rise && bit_q == 4'h8 && first_q) begin
            dir_q   <= word_q[0];
            match_q <= word_q[7:4] == TYPE_CODE && word_q[3:1] == strap;
        end
    end
    // Length of device low drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 16'h0000;
        end else begin
            low_q <= d_sda_oe_n ? 16'h0000 : low_q + 16'h0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ninth; rise && bit_q == 4'h8; endsequence
    sequence s_data;  rise && bit_q != 4'h8; endsequence
    sequence s_stop;  scl && scl_q && !sda_q && sda; endsequence

    AST_ADDR_ACK: assert property (
        s_ninth ##0 first_q |-> (!d_sda_oe_n) ==
            (word_q[7:4] == TYPE_CODE && word_q[3:1] == strap))
        else $error("Address word acknowledge wrong");
    AST_WR_ACK: assert property (
        s_ninth ##0 (!first_q && match_q && !dir_q) |-> !d_sda_oe_n)
        else $error("Written byte not acknowledged");
    AST_RD_REL: assert property (
        s_ninth ##0 (!first_q && dir_q) |-> d_sda_oe_n)
        else $error("Device holds line in master acknowledge");
    AST_RX_QUIET: assert property (
        s_data ##0 (first_q || !dir_q) |-> d_sda_oe_n)
        else $error("Device drives while master sends");
    AST_EDGE: assert property (
        $changed(d_sda_oe_n) |-> !scl)
        else $error("Device output changed while clock high");
    AST_OPEN_DRAIN: assert property (
        !d_sda_oe_n |-> !d_sda_o)
        else $error("Device drives line high");
    AST_STOP_REL: assert property (
        s_stop |=> d_sda_oe_n [*4])
        else $error("Device drives after stop");
    AST_START_REL: assert property (
        start |-> d_sda_oe_n && $stable(d_sda_oe_n))
        else $error("Device drives at start");
    AST_HOLD_MAX: assert property (
        low_q < 16'(HOLD_MAX))
        else $error("Device holds line low too long");
    AST_M_ACK_REL: assert property (
        s_ninth ##0 (first_q || !dir_q) |-> m_sda_oe_n)
        else $error("Master holds line in device acknowledge");
    AST_M_DRAIN: assert property (
        !m_sda_oe_n |-> !m_sda_o)
        else $error("Master drives line high");
endmodule : isms_link_checker
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench: APB commands through the master to the device.
// Assumes master and device face each other over isms_link_if.
`default_nettype none
module tb_top
    import isms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         Q    = 6;
    localparam logic [3:0] K_ST = 4'(4'h1 << CMD_START);
    localparam logic [3:0] K_SP = 4'(4'h1 << CMD_STOP);
    localparam logic [3:0] K_RD = 4'(4'h1 << CMD_READ);
    localparam logic [3:0] K_NK = 4'(4'h1 << CMD_NACK);
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  strap   = 3'b101;
    logic        wp      = 1'b0;
    logic [31:0] rd;
    logic        er;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [7:0]  pat [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};

    always #2 pclk = ~pclk;

    isms_link_if link_if ();
    isms_master #(.QTR(Q)) isms_master_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .link    (link_if)
    );
    isms_device isms_device_inst (
        .pclk              (pclk),
        .presetn           (presetn),
        .select_strap_high (strap[2]),
        .select_strap_mid  (strap[1]),
        .select_strap_low  (strap[0]),
        .write_protect     (wp),
        .link              (link_if)
    );
    isms_link_checker #(.QTR(Q)) isms_link_checker_inst (
        .pclk              (pclk),
        .presetn           (presetn),
        .scl               (link_if.scl),
        .sda               (link_if.sda),
        .m_sda_o           (link_if.m_sda_o),
        .m_sda_oe_n        (link_if.m_sda_oe_n),
        .d_sda_o           (link_if.d_sda_o),
        .d_sda_oe_n        (link_if.d_sda_oe_n),
        .select_strap_high (strap[2]),
        .select_strap_mid  (strap[1]),
        .select_strap_low  (strap[0])
    );

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd       = prdata;
        er       = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One byte on the link, then wait for idle
    task automatic send(input logic [3:0] cmd, input logic [7:0] tx,
                        input logic ack);
        apb(1'b1, REG_TX, {24'h00_0000, tx});
        apb(1'b1, REG_CMD, {28'h000_0000, cmd});
        rd = 32'h0000_0001;
        while (rd[STAT_BUSY] !== 1'b0) apb(1'b0, REG_STAT, 32'h0000_0000);
        if (!cmd[CMD_READ]) begin
            check("ack", 32'(rd[STAT_ACK]), 32'(ack));
        end
    endtask : send

    task automatic recv(input logic [3:0] cmd, input logic [7:0] exp);
        send(cmd, 8'h00, 1'b0);
        apb(1'b0, REG_RX, 32'h0000_0000);
        check("rx", rd, {24'h00_0000, exp});
    endtask : recv

    function automatic logic [7:0] wd(input logic [2:0] s, input logic r);
        return {DEF_TYPE_CODE, s, r};
    endfunction : wd

    task automatic addr(input logic [15:0] a);
        send(K_ST, wd(3'b101, 1'b0), 1'b1);
        send(4'h0, a[15:8], 1'b1);
        send(4'h0, a[7:0], 1'b1);
    endtask : addr

    initial begin : main
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // Page write over the top of the array, no stop
        addr(16'h1FFE);
        foreach (pat[i]) send(4'h0, pat[i], 1'b1);
        // Random then sequential read, upper address bits set
        addr(16'hFFFE);
        send(K_ST, wd(3'b101, 1'b1), 1'b1);
        recv(K_RD, pat[0]);
        recv(K_RD, pat[1]);
        recv(K_RD | K_NK | K_SP, pat[2]);
        // Current address read
        send(K_ST, wd(3'b101, 1'b1), 1'b1);
        recv(K_RD | K_NK | K_SP, pat[3]);
        // Protected byte write, then read while protected
        wp <= 1'b1;
        addr(16'h1FFE);
        send(K_SP, 8'h00, 1'b1);
        addr(16'h1FFE);
        send(K_ST, wd(3'b101, 1'b1), 1'b1);
        recv(K_RD | K_NK | K_SP, pat[0]);
        wp <= 1'b0;
        // Type and select mismatches
        send(K_ST | K_SP, {~DEF_TYPE_CODE, 3'b101, 1'b0}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            send(K_ST|K_SP, wd(3'b101 ^ (3'b001 << i), 1'b0), 1'b0);
        end
        strap <= 3'b011;
        send(K_ST | K_SP, wd(3'b011, 1'b0), 1'b1);
        send(K_ST | K_SP, wd(3'b110, 1'b0), 1'b0);
        // Unmapped register
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped err", 32'(er), 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
        // Transmit register reads back the last byte written
        apb(1'b0, REG_TX, 32'h0000_0000);
        check("tx readback", rd, {24'h00_0000, wd(3'b110, 1'b0)});
        end_of_test();
    end

    initial begin : watchdog
        #200_000;
        mismatches++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
